// file: hw/fdr_defs.svh
`ifndef FDR_DEFS_SVH
`define FDR_DEFS_SVH

// ==========================================================================
// Register offsets (7-bit register address space).
// ==========================================================================
`define FDR_ADDR_RB_PRIMARY  7'h0A
`define FDR_ADDR_CARRIER_LO  7'h0D
`define FDR_ADDR_PLAIN_DEV   7'h0E
`define FDR_ADDR_SHAPED_DEV  7'h0F
`define FDR_ADDR_TX_RB_ALIAS 7'h10
`define FDR_ADDR_SOFT_RESET  7'h17
`define FDR_ADDR_RSVD_A      7'h18
`define FDR_ADDR_RSVD_B      7'h19

// ==========================================================================
// Reset values.
// ==========================================================================
`define FDR_RST_CARRIER_LO   8'h00
`define FDR_RST_PLAIN_DEV    7'h28
`define FDR_RST_SHAPED_DEV   4'h4
`define FDR_RST_ALIAS_CTRL   3'h0
`define FDR_RST_RSVD         8'h00

// ==========================================================================
// Field positions.
// ==========================================================================
`define FDR_BIT_READBACK     0
`define FDR_BIT_TX_EN        1
`define FDR_BIT_SOFT_RESET   0

// ==========================================================================
// Timing: shaping base tick in ns and the derived count at 4 ns per cycle.
// ==========================================================================
`define FDR_CLK_PERIOD_NS    4
`define FDR_SHAPE_TICK_NS    5000
`define FDR_SHAPE_TICK_CYC   (`FDR_SHAPE_TICK_NS / `FDR_CLK_PERIOD_NS)
`define FDR_SHAPE_STEPS      16
`define FDR_SHAPED_SCALE     10

`endif

// file: hw/fdr_pkg.sv
package fdr_pkg;

  // ========================================================================
  // Serial frame states.
  // ========================================================================
  typedef enum logic [1:0] {FDR_IDLE, FDR_CMD, FDR_DATA} fdr_state_t;

  // Configuration that leaves the block toward the synthesizer and modulator.
  typedef struct packed {
    logic [23:0] carrier_word;     // Full frequency word, upper part from outside.
    logic [7:0]  mark_offset;      // Mark offset in plain deviation units.
    logic        tx_enable;        // Transmission enable from the alias bit.
    logic        readback_enable;  // Four-wire readback on the clock-out pin.
    logic        soft_reset_active;// Digital logic is held in reset.
  } fdr_cfg_t;

endpackage

// file: hw/fdr_regs.sv
`timescale 1ns/1ns
`include "fdr_defs.svh"

// Functional notes
// - Unshaped FSK uses plain seven-bit deviation
// - Shaped FSK uses four-bit shaped deviation
// - Alias bit one gates transmission
// - Bit zero enables clock-out readback
// - Readback bits at both addresses share storage
// - Writing one to reset bit enters reset
// - Carrier word joins three bytes, low here
// - Shaped transition takes sixteen timed steps
module fdr_regs
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                spi_sclk,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_sdi,
  output logic                     spi_sdo,
  output logic                     spi_sdo_oe,
  input  wire logic                tx_data,
  input  wire logic [15:0]         carrier_word_high,
  input  wire logic                modulation_select,
  input  wire logic                shaping_enable,
  input  wire logic [5:0]          shaping_step_time,
  output fdr_pkg::fdr_cfg_t        cfg,
  output logic [3:0]               shape_step,
  output logic                     shape_active
);

  // ========================================================================
  // Pin synchronisers: sclk, cs_n, sdi, tx_data each pass two flip-flops.
  // ========================================================================
  logic [3:0] pin_raw;   // Raw pin levels.
  logic [3:0] sync1_reg; // First stage, read only by the second stage.
  logic [3:0] sync2_reg; // Second stage, safe to use.
  logic [3:0] dly_reg;   // Delayed copy for edge detection.

  assign pin_raw = {tx_data, spi_sdi, spi_cs_n, spi_sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      // Each pin gets its own two-stage synchroniser and an edge stage.
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync2_reg[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          dly_reg[gi]   <= (gi == 1) ? 1'b1 : 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          dly_reg[gi]   <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise; // Sample edge of the serial clock.
  logic sclk_fall; // Shift-out edge of the serial clock.
  logic cs_act;    // Chip select asserted.
  logic data_edge; // Transmit data changed level.

  assign sclk_rise = sync2_reg[0] & ~dly_reg[0];
  assign sclk_fall = ~sync2_reg[0] & dly_reg[0];
  assign cs_act    = ~sync2_reg[1];
  assign data_edge = sync2_reg[3] ^ dly_reg[3];

  // ========================================================================
  // State: serial engine and register file.
  // ========================================================================
  fdr_pkg::fdr_state_t state_reg, state_next; // Frame state.
  logic [2:0]  bitcnt_reg,  bitcnt_next;      // Bit within current byte.
  logic [7:0]  shin_reg,    shin_next;        // Incoming shift register.
  logic [7:0]  shout_reg,   shout_next;       // Outgoing shift register.
  logic        rd_reg,      rd_next;          // Frame is a read.
  logic [6:0]  addr_reg,    addr_next;        // Current register address.
  logic        sdo_reg,     sdo_next;         // Serial output bit.
  logic [7:0]  clo_reg,     clo_next;         // Carrier word low byte.
  logic [6:0]  pdev_reg,    pdev_next;        // Plain deviation.
  logic [3:0]  sdev_reg,    sdev_next;        // Shaped deviation.
  logic [2:0]  alias_reg,   alias_next;       // Reserved, tx enable, readback.
  logic        soft_reg,    soft_next;        // Soft reset bit.
  logic [7:0]  rsva_reg,    rsva_next;        // Reserved config A.
  logic [7:0]  rsvb_reg,    rsvb_next;        // Reserved config B.
  logic [7:0]  rdata;                         // Read mux output.
  logic [7:0]  byte_in;                       // Completed byte.
  logic        byte_done;                     // Last bit of a byte sampled.
  logic        wr_commit;                     // Data byte written this cycle.

  assign byte_in   = {shin_reg[6:0], sync2_reg[2]};
  assign byte_done = cs_act & sclk_rise & (bitcnt_reg == 3'd7);
  assign wr_commit = byte_done & (state_reg == fdr_pkg::FDR_DATA) & ~rd_reg;

  // Read mux; unmapped addresses read as zero.
  always_comb
  begin
    case (addr_reg)
      `FDR_ADDR_RB_PRIMARY:  rdata = {7'h00, alias_reg[`FDR_BIT_READBACK]};
      `FDR_ADDR_CARRIER_LO:  rdata = clo_reg;
      `FDR_ADDR_PLAIN_DEV:   rdata = {1'b0, pdev_reg};
      `FDR_ADDR_SHAPED_DEV:  rdata = {4'h0, sdev_reg};
      `FDR_ADDR_TX_RB_ALIAS: rdata = {5'h00, alias_reg};
      `FDR_ADDR_SOFT_RESET:  rdata = {7'h00, soft_reg};
      `FDR_ADDR_RSVD_A:      rdata = rsva_reg;
      `FDR_ADDR_RSVD_B:      rdata = rsvb_reg;
      default:               rdata = 8'h00;
    endcase
  end

  // Next-state logic for the serial engine and every register. The serial
  // engine stays live under soft reset so the host can clear the bit.
  always_comb
  begin
    state_next  = state_reg;
    bitcnt_next = bitcnt_reg;
    shin_next   = shin_reg;
    shout_next  = shout_reg;
    rd_next     = rd_reg;
    addr_next   = addr_reg;
    sdo_next    = sdo_reg;
    clo_next    = clo_reg;
    pdev_next   = pdev_reg;
    sdev_next   = sdev_reg;
    alias_next  = alias_reg;
    soft_next   = soft_reg;
    rsva_next   = rsva_reg;
    rsvb_next   = rsvb_reg;
    case (state_reg)
      fdr_pkg::FDR_IDLE:
      begin
        // A new frame always opens with a command byte.
        if (cs_act)
        begin
          state_next  = fdr_pkg::FDR_CMD;
          bitcnt_next = 3'd0;
        end
      end
      fdr_pkg::FDR_CMD, fdr_pkg::FDR_DATA:
      begin
        if (!cs_act)
        begin
          state_next = fdr_pkg::FDR_IDLE;
        end
        else if (sclk_rise)
        begin
          shin_next   = byte_in;
          bitcnt_next = bitcnt_reg + 3'd1;
          if (byte_done && state_reg == fdr_pkg::FDR_CMD)
          begin
            // Command byte: bit 7 selects read, bits 6:0 the address.
            state_next = fdr_pkg::FDR_DATA;
            rd_next    = byte_in[7];
            addr_next  = byte_in[6:0];
          end
          else if (byte_done)
          begin
            // Bursts walk upward through the address space.
            addr_next = addr_reg + 7'd1;
          end
        end
        // Outgoing data is loaded after the command byte and after every
        // data byte, from the address that the next byte will use.
        if (sclk_fall)
        begin
          if (bitcnt_reg == 3'd0 && state_reg == fdr_pkg::FDR_DATA)
          begin
            sdo_next   = rdata[7];
            shout_next = {rdata[6:0], 1'b0};
          end
          else
          begin
            sdo_next   = shout_reg[7];
            shout_next = {shout_reg[6:0], 1'b0};
          end
        end
      end
      default:
      begin
        state_next = fdr_pkg::FDR_IDLE;
      end
    endcase

    // Register writes.
    if (wr_commit)
    begin
      case (addr_reg)
        `FDR_ADDR_RB_PRIMARY:  alias_next[`FDR_BIT_READBACK] = byte_in[0];
        `FDR_ADDR_CARRIER_LO:  clo_next   = byte_in;
        `FDR_ADDR_PLAIN_DEV:   pdev_next  = byte_in[6:0];
        `FDR_ADDR_SHAPED_DEV:  sdev_next  = byte_in[3:0];
        `FDR_ADDR_TX_RB_ALIAS: alias_next = byte_in[2:0];
        `FDR_ADDR_SOFT_RESET:  soft_next  = byte_in[`FDR_BIT_SOFT_RESET];
        `FDR_ADDR_RSVD_A:      rsva_next  = byte_in;
        `FDR_ADDR_RSVD_B:      rsvb_next  = byte_in;
        default:               soft_next  = soft_reg;
      endcase
    end

    // While soft reset stands, every configuration register is held at its
    // reset value; only the reset bit itself and the serial engine survive.
    if (soft_reg)
    begin
      clo_next   = `FDR_RST_CARRIER_LO;
      pdev_next  = `FDR_RST_PLAIN_DEV;
      sdev_next  = `FDR_RST_SHAPED_DEV;
      alias_next = `FDR_RST_ALIAS_CTRL;
      rsva_next  = `FDR_RST_RSVD;
      rsvb_next  = `FDR_RST_RSVD;
    end
  end

  // Register stage for the serial engine and register file.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= fdr_pkg::FDR_IDLE;
      bitcnt_reg <= 3'd0;
      shin_reg   <= 8'h00;
      shout_reg  <= 8'h00;
      rd_reg     <= 1'b0;
      addr_reg   <= 7'h00;
      sdo_reg    <= 1'b0;
      clo_reg    <= `FDR_RST_CARRIER_LO;
      pdev_reg   <= `FDR_RST_PLAIN_DEV;
      sdev_reg   <= `FDR_RST_SHAPED_DEV;
      alias_reg  <= `FDR_RST_ALIAS_CTRL;
      soft_reg   <= 1'b0;
      rsva_reg   <= `FDR_RST_RSVD;
      rsvb_reg   <= `FDR_RST_RSVD;
    end
    else
    begin
      state_reg  <= state_next;
      bitcnt_reg <= bitcnt_next;
      shin_reg   <= shin_next;
      shout_reg  <= shout_next;
      rd_reg     <= rd_next;
      addr_reg   <= addr_next;
      sdo_reg    <= sdo_next;
      clo_reg    <= clo_next;
      pdev_reg   <= pdev_next;
      sdev_reg   <= sdev_next;
      alias_reg  <= alias_next;
      soft_reg   <= soft_next;
      rsva_reg   <= rsva_next;
      rsvb_reg   <= rsvb_next;
    end
  end

  // The output driver is enabled only during the data phase of a read.
  assign spi_sdo    = sdo_reg;
  assign spi_sdo_oe = cs_act & rd_reg & (state_reg == fdr_pkg::FDR_DATA);

  // ========================================================================
  // Shaped transition timer: 16 steps, each (step_time + 1) base ticks.
  // ========================================================================
  logic [11:0] tick_reg, tick_next;   // Base tick divider.
  logic [5:0]  dwell_reg, dwell_next; // Ticks spent on current step.
  logic [3:0]  step_reg, step_next;   // Current step index.
  logic        act_reg, act_next;     // Transition in progress.
  logic        tick_en;               // One-cycle base tick enable.

  assign tick_en = (tick_reg == 12'(`FDR_SHAPE_TICK_CYC - 1));

  // Next values; a data edge restarts the profile and its base tick, so a fast
  // edge is not lost and the first step lasts as long as every other step.
  always_comb
  begin
    tick_next  = tick_en ? 12'd0 : tick_reg + 12'd1;
    dwell_next = dwell_reg;
    step_next  = step_reg;
    act_next   = act_reg;
    if (data_edge && modulation_select && shaping_enable)
    begin
      act_next   = 1'b1;
      step_next  = 4'd0;
      dwell_next = 6'd0;
      tick_next  = 12'd0;
    end
    else if (act_reg && tick_en)
    begin
      if (dwell_reg == shaping_step_time)
      begin
        dwell_next = 6'd0;
        step_next  = step_reg + 4'd1;
        act_next   = (step_reg != 4'(`FDR_SHAPE_STEPS - 1));
      end
      else
      begin
        dwell_next = dwell_reg + 6'd1;
      end
    end
    if (soft_reg)
    begin
      act_next  = 1'b0;
      step_next = 4'd0;
      tick_next = 12'd0;
      dwell_next = 6'd0;
    end
  end

  // Register stage for the shaping timer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_reg  <= 12'd0;
      dwell_reg <= 6'd0;
      step_reg  <= 4'd0;
      act_reg   <= 1'b0;
    end
    else
    begin
      tick_reg  <= tick_next;
      dwell_reg <= dwell_next;
      step_reg  <= step_next;
      act_reg   <= act_next;
    end
  end

  assign shape_step   = step_reg;
  assign shape_active = act_reg;

  // ========================================================================
  // Configuration outputs. Shaped deviation is ten times coarser.
  // ========================================================================
  assign cfg.carrier_word      = {carrier_word_high, clo_reg};
  assign cfg.mark_offset       = (modulation_select && shaping_enable)
                                 ? 8'(sdev_reg * `FDR_SHAPED_SCALE)
                                 : {1'b0, pdev_reg};
  assign cfg.tx_enable         = alias_reg[`FDR_BIT_TX_EN] & ~soft_reg;
  assign cfg.readback_enable   = alias_reg[`FDR_BIT_READBACK];
  assign cfg.soft_reset_active = soft_reg;

  // ========================================================================
  // Assertions.
  // ========================================================================
  sequence s_soft_write;
    wr_commit && addr_reg == `FDR_ADDR_SOFT_RESET && byte_in[0];
  endsequence

  a_plain_dev_used: assert property (@(posedge clk) disable iff (!rst_n)
    !shaping_enable |-> cfg.mark_offset == {1'b0, pdev_reg})
    else $error("plain deviation not used");
  a_shaped_dev_used: assert property (@(posedge clk) disable iff (!rst_n)
    modulation_select && shaping_enable |-> cfg.mark_offset == sdev_reg * 8'd10)
    else $error("shaped deviation not used");
  a_tx_alias_gate: assert property (@(posedge clk) disable iff (!rst_n)
    wr_commit && addr_reg == `FDR_ADDR_TX_RB_ALIAS && !soft_reg
      |=> cfg.tx_enable == $past(byte_in[1]))
    else $error("tx enable alias not applied");
  a_readback_pin: assert property (@(posedge clk) disable iff (!rst_n)
    wr_commit && addr_reg == `FDR_ADDR_TX_RB_ALIAS && !soft_reg
      |=> cfg.readback_enable == $past(byte_in[0]))
    else $error("readback enable not applied");
  a_alias_shared: assert property (@(posedge clk) disable iff (!rst_n)
    wr_commit && addr_reg == `FDR_ADDR_RB_PRIMARY && !soft_reg
      |=> cfg.readback_enable == $past(byte_in[0]))
    else $error("primary readback write lost");
  a_soft_enter: assert property (@(posedge clk) disable iff (!rst_n)
    s_soft_write |=> soft_reg ##1 (pdev_reg == `FDR_RST_PLAIN_DEV))
    else $error("soft reset not entered");
  a_soft_hold: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reg |=> !cfg.tx_enable && !act_reg && sdev_reg == `FDR_RST_SHAPED_DEV)
    else $error("logic not held in soft reset");
  a_reserved_store: assert property (@(posedge clk) disable iff (!rst_n)
    wr_commit && addr_reg == `FDR_ADDR_RSVD_A && !soft_reg
      |=> rsva_reg == $past(byte_in))
    else $error("reserved byte not stored");
  a_carrier_low: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.carrier_word[7:0] == clo_reg && cfg.carrier_word[23:8] == carrier_word_high)
    else $error("carrier word misassembled");
  a_step_advance: assert property (@(posedge clk) disable iff (!rst_n)
    act_reg && tick_en && dwell_reg == shaping_step_time && !data_edge && !soft_reg
      |=> step_reg == $past(step_reg) + 4'd1)
    else $error("shaping step did not advance");

endmodule // fdr_regs

// file: testbench/fdr_host.sv
`timescale 1ns/1ns

// ==========================================================================
// Host controller model: mode 0 serial master, one data byte per frame.
// ==========================================================================
module fdr_host
(
  input  wire logic clk,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi
);
  localparam int HALF = 5;  // Clocks per half period; the port needs four at least.
  logic last_sdo;           // Last level seen on the shared data-out wire.
  // A released data-out wire must not look like a held value, so show its inverse.
  wire  sdo_line = spi_sdo_oe ? spi_sdo : ~last_sdo;

  // Idle pins: clock low, select high.
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
    last_sdo = 1'b0;
  end

  // Every pin change happens on a falling system clock edge.
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One frame: command byte, then one data byte; read bits are sampled on sclk rise.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] sh;
    sh       = {cmd, wdata};
    rdata    = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdi = sh[i];
      wait_clk(HALF);
      spi_sclk = 1'b1;
      if (i < 8)
      begin
        rdata[i] = sdo_line;
        last_sdo = sdo_line;
      end
      wait_clk(HALF);
      spi_sclk = 1'b0;
    end
    wait_clk(HALF);
    spi_cs_n = 1'b1;
    spi_sdi  = ~spi_sdi;  // Unselected input wanders; the device must ignore it.
    wait_clk(HALF + 1);   // Gap between frames longer than four clocks.
  endtask
endmodule // fdr_host

// file: testbench/testbench.sv
`timescale 1ns/1ns
`include "fdr_defs.svh"

// ==========================================================================
// Self-checking bench for the deviation, alias and soft reset registers.
// ==========================================================================
module testbench;
  typedef struct packed {
    logic [6:0] addr;  // Register address.
    logic [7:0] rst;   // Value expected after reset.
    logic [7:0] wd;    // Value written.
    logic [7:0] rd;    // Value expected back.
  } fdr_row_t;

  logic              clk;
  logic              rst_n;
  logic              spi_sclk;
  logic              spi_cs_n;
  logic              spi_sdi;
  logic              spi_sdo;
  logic              spi_sdo_oe;
  logic              tx_data;
  logic [15:0]       carrier_word_high;
  logic              modulation_select;
  logic              shaping_enable;
  logic [5:0]        shaping_step_time;
  fdr_pkg::fdr_cfg_t cfg;
  logic [3:0]        shape_step;
  logic              shape_active;
  int                bad_count;
  int                check_count;
  logic [7:0]        v;

  // Unimplemented high bits read zero; reserved bits are kept; unmapped reads zero.
  fdr_row_t rows [7] = '{
    '{`FDR_ADDR_CARRIER_LO,  8'h00, 8'hA5, 8'hA5},
    '{`FDR_ADDR_PLAIN_DEV,   8'h28, 8'hFF, 8'h7F},
    '{`FDR_ADDR_SHAPED_DEV,  8'h04, 8'hFF, 8'h0F},
    '{`FDR_ADDR_TX_RB_ALIAS, 8'h00, 8'h07, 8'h07},
    '{`FDR_ADDR_RSVD_A,      8'h00, 8'hFF, 8'hFF},
    '{`FDR_ADDR_RSVD_B,      8'h00, 8'h5A, 8'h5A},
    '{7'h1F,                 8'h00, 8'hFF, 8'h00}};

  fdr_regs dut (.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .tx_data(tx_data),
    .carrier_word_high(carrier_word_high), .modulation_select(modulation_select),
    .shaping_enable(shaping_enable), .shaping_step_time(shaping_step_time), .cfg(cfg),
    .shape_step(shape_step), .shape_active(shape_active));

  fdr_host host (.clk(clk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

  // Free-running 250 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare one value with its expectation and count the outcome.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.xfer({1'b0, a}, d, dummy);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer({1'b1, a}, 8'h00, d);
  endtask

  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence: table of register cases, then hand-written awkward cases.
  initial
  begin
    int n;
    logic [3:0] top;
    bad_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    tx_data = 1'b0;
    carrier_word_high = 16'h13B0;
    modulation_select = 1'b1;
    shaping_enable = 1'b0;
    shaping_step_time = 6'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    host.wait_clk(6);
    // Reset value, write, readback for every row; reserved bits written as ones, except reserved B written 5A.
    foreach (rows[i])
    begin
      rd(rows[i].addr, v);
      check({16'h0, v}, {16'h0, rows[i].rst});
      wr(rows[i].addr, rows[i].wd);
      rd(rows[i].addr, v);
      check({16'h0, v}, {16'h0, rows[i].rd});
    end
    rd(`FDR_ADDR_SOFT_RESET, v);
    check({16'h0, v}, 24'h0);
    $display("test register table done");
    // Outputs driven by the stored values.
    check(cfg.carrier_word, {carrier_word_high, 8'hA5});
    check({16'h0, cfg.mark_offset}, 24'h7F);
    check({23'h0, cfg.tx_enable}, 24'h1);
    check({23'h0, cfg.readback_enable}, 24'h1);
    shaping_enable = 1'b1;
    host.wait_clk(4);
    check({16'h0, cfg.mark_offset}, 24'h96);
    // Shaping without FSK selected must fall back to the plain deviation.
    modulation_select = 1'b0;
    host.wait_clk(1);
    check({16'h0, cfg.mark_offset}, 24'h7F);
    modulation_select = 1'b1;
    $display("test outputs done");
    // Primary and alias readback bits share one control.
    wr(`FDR_ADDR_RB_PRIMARY, 8'h00);
    rd(`FDR_ADDR_TX_RB_ALIAS, v);
    check({16'h0, v}, 24'h06);
    check({23'h0, cfg.readback_enable}, 24'h0);
    wr(`FDR_ADDR_TX_RB_ALIAS, 8'h05);
    rd(`FDR_ADDR_RB_PRIMARY, v);
    check({16'h0, v}, 24'h01);
    check({23'h0, cfg.tx_enable}, 24'h0);
    $display("test alias done");
    // A data edge starts a sixteen-step ramp, each step one base tick long.
    tx_data = 1'b1;
    n = 0;
    while (shape_active !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check({23'h0, shape_active}, 24'h1);
    n = 0;
    top = 4'h0;
    while (shape_active === 1'b1 && n < 30000)
    begin
      @(negedge clk);
      n++;
      if (shape_step > top)
        top = shape_step;
    end
    check({23'h0, (n >= 16 * `FDR_SHAPE_TICK_CYC - 8 &&
                   n <= 16 * `FDR_SHAPE_TICK_CYC + 8)}, 24'h1);
    check({20'h0, top}, 24'hF);
    $display("test ramp done");
    // Soft reset returns and holds the configuration until the bit is cleared.
    wr(`FDR_ADDR_SOFT_RESET, 8'h01);
    rd(`FDR_ADDR_PLAIN_DEV, v);
    check({16'h0, v}, 24'h28);
    check({23'h0, cfg.soft_reset_active}, 24'h1);
    check({23'h0, cfg.tx_enable}, 24'h0);
    wr(`FDR_ADDR_PLAIN_DEV, 8'h11);
    rd(`FDR_ADDR_PLAIN_DEV, v);
    check({16'h0, v}, 24'h28);
    rd(`FDR_ADDR_SOFT_RESET, v);
    check({16'h0, v}, 24'h01);
    wr(`FDR_ADDR_SOFT_RESET, 8'h00);
    check({23'h0, cfg.soft_reset_active}, 24'h0);
    wr(`FDR_ADDR_PLAIN_DEV, 8'h33);
    rd(`FDR_ADDR_PLAIN_DEV, v);
    check({16'h0, v}, 24'h33);
    $display("test soft reset done");
    // A second hardware reset in mid-run restores the defaults.
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check({16'h0, cfg.mark_offset}, 24'h28);
    rst_n = 1'b1;
    host.wait_clk(6);
    rd(`FDR_ADDR_PLAIN_DEV, v);
    check({16'h0, v}, 24'h28);
    $display("test hard reset done");
    summarize();
  end
endmodule // testbench
